/* File: design/pcc_clamp_gen.sv */
// Purpose: Per-line clamp start strobe and clamp pulse generator.
// Assumes: One aclk cycle per pixel; trigger is the line sync trailing edge.
// Notes:   Pixel 0 is the cycle after the trigger is seen.
`timescale 1ns/1ps
module pcc_clamp_gen
    import pcc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Line timing
    input wire logic line_trigger,
    input wire logic [12:0] start_pixel,
    input wire logic [7:0] clamp_width,
    // Results
    output logic start_strobe,
    output logic clamp_level
);

    typedef struct packed {
        logic run;
        logic [12:0] cnt;
        logic [7:0] wcnt;
        logic strobe;
        logic clamp;
    } pcc_gen_s;

    pcc_gen_s gen_q;
    pcc_gen_s gen_d;

    // Pixel counter from trigger, strobe at start pixel, then width countdown
    always_comb begin
        gen_d = gen_q;
        gen_d.strobe = 1'b0;
        if (line_trigger) begin
            gen_d.run = 1'b1;
            gen_d.cnt = 13'h0000;
        end else if (gen_q.run) begin
            if (gen_q.cnt == start_pixel) begin
                gen_d.run = 1'b0; // Once per line
                gen_d.strobe = 1'b1;
                if (clamp_width >= MIN_CLAMP_WIDTH) begin
                    gen_d.clamp = 1'b1;
                    gen_d.wcnt = clamp_width;
                end
            end else begin
                gen_d.cnt = gen_q.cnt + 13'h0001;
            end
        end
        if (gen_q.clamp) begin
            gen_d.wcnt = gen_q.wcnt - 8'h01;
            if (gen_q.wcnt == 8'h01) begin
                gen_d.clamp = 1'b0; // Width in pixels
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_q <= '0;
        end else begin
            gen_q <= gen_d;
        end
    end

    assign start_strobe = gen_q.strobe;
    assign clamp_level = gen_q.clamp;

endmodule : pcc_clamp_gen

/* File: design/pcc_pkg.sv */
// Purpose: Shared constants for the loop hold and clamp control block.
// Assumes: Register word index sits in byte address bits [7:2].
// Notes:   Offsets are word indices; byte address is four times the index.
package pcc_pkg;

    // Register word indices
    localparam logic [5:0] IDX_BANDWIDTH = 6'h0d;
    localparam logic [5:0] IDX_LEN_HIGH = 6'h0e;
    localparam logic [5:0] IDX_LEN_LOW = 6'h0f;
    localparam logic [5:0] IDX_PHASE = 6'h10;
    localparam logic [5:0] IDX_HOLD_BEFORE = 6'h11;
    localparam logic [5:0] IDX_HOLD_AFTER = 6'h12;
    localparam logic [5:0] IDX_MISC = 6'h13;
    localparam logic [5:0] IDX_START_HIGH = 6'h14;
    localparam logic [5:0] IDX_START_LOW = 6'h15;
    localparam logic [5:0] IDX_CLAMP_WIDTH = 6'h16;
    localparam logic [5:0] IDX_INPUT_CFG = 6'h05;
    localparam logic [5:0] IDX_BLACK_CFG = 6'h17;
    localparam logic [5:0] IDX_STATUS = 6'h20;

    // Reset values
    localparam logic [7:0] RST_BANDWIDTH = 8'h0e;
    localparam logic [7:0] RST_LEN_HIGH = 8'h03;
    localparam logic [7:0] RST_LEN_LOW = 8'h20;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_HOLD_BEFORE = 8'h08;
    localparam logic [7:0] RST_HOLD_AFTER = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;
    localparam logic [7:0] RST_START_HIGH = 8'h00;
    localparam logic [7:0] RST_START_LOW = 8'h00;
    localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
    localparam logic [7:0] RST_INPUT_CFG = 8'h00;
    localparam logic [7:0] RST_BLACK_CFG = 8'h00;

    // Field positions
    localparam int CORNER_LSB = 1;
    localparam int PEAK_LSB = 4;
    localparam int MISC_LOCK_FIRST = 0;
    localparam int MISC_LOCK_SECOND = 1;
    localparam int MISC_PIN_OFF = 3;
    localparam int MISC_FN_LSB = 4;
    localparam int MISC_XTAL_HALF = 6;
    localparam int MISC_XTAL_OFF = 7;
    localparam int CFG_CHANNEL = 0;
    localparam int CFG_DC_COUPLED = 1;
    localparam int CFG_HOLD_CLAMP = 5;
    localparam int BLACK_DISABLE = 0;

    // Field masks that make reserved bits read as zero
    localparam logic [7:0] MASK_LEN_HIGH = 8'h3f;
    localparam logic [7:0] MASK_PHASE = 8'h3f;
    localparam logic [7:0] MASK_START_HIGH = 8'h1f;

    // Clamp width below this makes no pulse
    localparam logic [7:0] MIN_CLAMP_WIDTH = 8'h02;

    // Multipurpose pin function codes
    typedef enum logic [1:0] {
        PCC_PIN_INVERT = 2'b00,
        PCC_PIN_CLAMP = 2'b01,
        PCC_PIN_HOLD = 2'b10,
        PCC_PIN_EXTERNAL_PIXEL_CLOCK = 2'b11
    } pcc_pin_fn_e;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Timing: longest delay before a written gain or offset is applied when clamp is external
    localparam int CLK_FREQ_HZ = 125000000;
    localparam int APPLY_DELAY_MS = 100;
    localparam int APPLY_DELAY_CYCLES = APPLY_DELAY_MS * (CLK_FREQ_HZ / 1000);

endpackage : pcc_pkg

/* File: design/pcc_top.sv */
// Purpose: Loop line length, phase, hold interval and clamp control with
//          an AXI4-Lite register slave.
// Assumes: All pins synchronous to aclk; aclk stands in for the pixel clock.
// Notes:   Line syncs and frame sync are active high.
`timescale 1ns/1ps

module pcc_top
    import pcc_pkg::*;
#(
    parameter int APPLY_DELAY = APPLY_DELAY_CYCLES
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sync and pin inputs
    input wire logic first_line_sync_input,
    input wire logic second_line_sync_input,
    input wire logic frame_sync_input,
    input wire logic clock_invert_input,
    input wire logic crystal_clock_input,
    input wire logic gain_offset_written,
    // Analog front end settings
    output logic [2:0] frontend_corner_select,
    output logic [3:0] peaking_code,
    // Pixel clock loop
    output logic [13:0] loop_line_length,
    output logic [5:0] sample_phase_code,
    output logic loop_ref_pulse,
    output logic loop_hold,
    output logic clock_invert_active,
    output logic external_pixel_clock,
    output logic external_pixel_clock_select,
    // Clamp and black level
    output logic clamp_pulse,
    output logic black_level_correction_start,
    output logic offset_update_pulse,
    // Crystal clock
    output logic crystal_clock_output
);

    typedef struct packed {
        // Bus slave
        logic aw_have;
        logic [31:0] aw_addr;
        logic w_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        // Registers
        logic [7:0] bandwidth;
        logic [7:0] len_high;
        logic [7:0] len_low;
        logic [7:0] phase;
        logic [7:0] hold_before;
        logic [7:0] hold_after;
        logic [7:0] misc;
        logic [7:0] start_high;
        logic [7:0] start_low;
        logic [7:0] clamp_width;
        logic [7:0] input_cfg;
        logic [7:0] black_cfg;
        logic [13:0] len_active;
        // Sync tracking
        logic hs_q;
        logic vs_q;
        logic pin_q;
        logic xtal_q;
        logic [11:0] frame_lines;
        logic [11:0] line_cnt;
        logic [7:0] post_cnt;
        logic hold;
        logic ref_pulse;
        // Clamp and apply
        logic clamp;
        logic blc_start;
        logic offset_load;
        logic pend;
        logic [23:0] tmo;
        // Crystal output
        logic xtal_div;
        logic xtal_out;
    } pcc_state_s;

    pcc_state_s st_q;
    pcc_state_s st_d;

    logic gen_strobe;
    logic gen_clamp;
    logic hs_sel;

    // Rising edge of a level against its previous sample
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction : rise

    // Word index valid only inside the low 256 bytes
    function automatic logic mapped(input logic [31:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        mapped = (addr[31:8] == 24'h000000) &&
            ((idx >= IDX_BANDWIDTH && idx <= IDX_BLACK_CFG) ||
             idx == IDX_INPUT_CFG || idx == IDX_STATUS);
    endfunction : mapped

    // Clamp timing runs from the incoming line sync trailing edge
    assign hs_sel = st_q.input_cfg[CFG_CHANNEL] ? second_line_sync_input
                                                : first_line_sync_input;

    pcc_clamp_gen i_pcc_clamp_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .line_trigger(st_q.hs_q & ~hs_sel),
        .start_pixel({st_q.start_high[4:0], st_q.start_low}),
        .clamp_width(st_q.clamp_width),
        .start_strobe(gen_strobe),
        .clamp_level(gen_clamp)
    );

    // Whole next state
    always_comb begin
        logic aw_now, w_now, wr_lane0, hs_lead, hs_trail, vs_lead, vs_trail;
        logic pin_eff, hold_int, pre_region, gate, int_clamp_mode, clamp_event, tmo_fire;
        logic [31:0] wr_addr;
        logic [7:0] wr_data;
        logic [1:0] pin_fn;
        aw_now = 1'b0;
        w_now = 1'b0;
        wr_addr = 32'h00000000;
        wr_data = 8'h00;
        wr_lane0 = 1'b0;
        hs_lead = 1'b0;
        hs_trail = 1'b0;
        vs_lead = 1'b0;
        vs_trail = 1'b0;
        pin_eff = 1'b0;
        pin_fn = 2'b00;
        hold_int = 1'b0;
        pre_region = 1'b0;
        gate = 1'b0;
        int_clamp_mode = 1'b0;
        clamp_event = 1'b0;
        tmo_fire = 1'b0;
        st_d = st_q;

        // Bus handshake; address and data may arrive in either order
        s_axi_awready = ~st_q.aw_have & ~st_q.bvalid;
        s_axi_wready = ~st_q.w_have & ~st_q.bvalid;
        s_axi_arready = ~st_q.rvalid;
        aw_now = st_q.aw_have | (s_axi_awvalid & s_axi_awready);
        w_now = st_q.w_have | (s_axi_wvalid & s_axi_wready);
        wr_addr = st_q.aw_have ? st_q.aw_addr : s_axi_awaddr;
        wr_data = st_q.w_have ? st_q.w_data : s_axi_wdata[7:0];
        wr_lane0 = st_q.w_have ? st_q.w_lane0 : s_axi_wstrb[0];
        if (s_axi_awvalid && s_axi_awready) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_d.w_have = 1'b1;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_lane0 = s_axi_wstrb[0];
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // Register write in the cycle both halves are held or arriving
        if (aw_now && w_now) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            if (mapped(wr_addr) && wr_lane0) begin
                case (wr_addr[7:2])
                    IDX_BANDWIDTH: st_d.bandwidth = wr_data;
                    IDX_LEN_HIGH: st_d.len_high = wr_data & MASK_LEN_HIGH;
                    IDX_LEN_LOW: begin
                        st_d.len_low = wr_data;
                        // High byte alone never reaches the loop
                        st_d.len_active = {st_q.len_high[5:0], wr_data};
                    end
                    IDX_PHASE: st_d.phase = wr_data & MASK_PHASE;
                    IDX_HOLD_BEFORE: st_d.hold_before = wr_data;
                    IDX_HOLD_AFTER: st_d.hold_after = wr_data;
                    IDX_MISC: st_d.misc = wr_data;
                    IDX_START_HIGH: st_d.start_high = wr_data & MASK_START_HIGH;
                    IDX_START_LOW: st_d.start_low = wr_data;
                    IDX_CLAMP_WIDTH: st_d.clamp_width = wr_data;
                    IDX_INPUT_CFG: st_d.input_cfg = wr_data;
                    IDX_BLACK_CFG: st_d.black_cfg = wr_data;
                    default: st_d.bandwidth = st_q.bandwidth; // Status is read only
                endcase
            end
        end

        // Register read, answered one cycle after the address is taken
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            st_d.rdata = 32'h00000000;
            if (mapped(s_axi_araddr)) begin
                case (s_axi_araddr[7:2])
                    IDX_BANDWIDTH: st_d.rdata[7:0] = st_q.bandwidth;
                    IDX_LEN_HIGH: st_d.rdata[7:0] = st_q.len_high;
                    IDX_LEN_LOW: st_d.rdata[7:0] = st_q.len_low;
                    IDX_PHASE: st_d.rdata[7:0] = st_q.phase;
                    IDX_HOLD_BEFORE: st_d.rdata[7:0] = st_q.hold_before;
                    IDX_HOLD_AFTER: st_d.rdata[7:0] = st_q.hold_after;
                    IDX_MISC: st_d.rdata[7:0] = st_q.misc;
                    IDX_START_HIGH: st_d.rdata[7:0] = st_q.start_high;
                    IDX_START_LOW: st_d.rdata[7:0] = st_q.start_low;
                    IDX_CLAMP_WIDTH: st_d.rdata[7:0] = st_q.clamp_width;
                    IDX_INPUT_CFG: st_d.rdata[7:0] = st_q.input_cfg;
                    IDX_BLACK_CFG: st_d.rdata[7:0] = st_q.black_cfg;
                    IDX_STATUS: st_d.rdata[17:0] = {gen_clamp, st_q.hold,
                        st_q.pend, 1'b0, st_q.len_active};
                    default: st_d.rdata = 32'h00000000;
                endcase
            end
        end

        // Sync edges from previous samples
        hs_lead = rise(st_q.hs_q, hs_sel);
        hs_trail = rise(hs_sel, st_q.hs_q);
        vs_lead = rise(st_q.vs_q, frame_sync_input);
        vs_trail = rise(frame_sync_input, st_q.vs_q);
        st_d.hs_q = hs_sel;
        st_d.vs_q = frame_sync_input;

        // Lock edge follows the bit of the selected input
        if (st_q.input_cfg[CFG_CHANNEL]) begin
            st_d.ref_pulse = st_q.misc[MISC_LOCK_SECOND] ? hs_lead : hs_trail;
        end else begin
            st_d.ref_pulse = st_q.misc[MISC_LOCK_FIRST] ? hs_lead : hs_trail;
        end

        // Multipurpose pin, forced low when disabled
        pin_eff = st_q.misc[MISC_PIN_OFF] ? 1'b0 : clock_invert_input;
        pin_fn = st_q.misc[MISC_FN_LSB +: 2];
        st_d.pin_q = pin_eff;

        // Frame length from the last frame lets hold start before frame sync
        if (vs_lead) begin
            st_d.frame_lines = st_q.line_cnt;
            st_d.line_cnt = 12'h000;
        end else if (hs_lead && st_q.line_cnt != 12'hfff) begin
            st_d.line_cnt = st_q.line_cnt + 12'h001;
        end
        pre_region = (st_q.frame_lines != 12'h000) &&
            ({1'b0, st_q.line_cnt} + {5'h00, st_q.hold_before} >=
             {1'b0, st_q.frame_lines});
        if (vs_trail) begin
            st_d.post_cnt = st_q.hold_after;
        end else if (hs_lead && st_q.post_cnt != 8'h00) begin
            st_d.post_cnt = st_q.post_cnt - 8'h01;
        end
        hold_int = pre_region | st_q.vs_q | (st_q.post_cnt != 8'h00);
        // External hold takes the pin and ignores line counts
        st_d.hold = (pin_fn == PCC_PIN_HOLD) ? pin_eff : hold_int;

        // Clamp source and gating
        gate = ~st_q.hold | st_q.input_cfg[CFG_HOLD_CLAMP];
        int_clamp_mode = (pin_fn != PCC_PIN_CLAMP);
        clamp_event = int_clamp_mode ? gen_strobe
                                     : rise(st_q.pin_q, pin_eff);
        st_d.clamp = ~st_q.input_cfg[CFG_DC_COUPLED] & gate &
            (int_clamp_mode ? gen_clamp : st_q.pin_q);
        st_d.blc_start = clamp_event & gate & ~st_q.black_cfg[BLACK_DISABLE];

        // Pending gain or offset write; bounded wait when clamp is external
        tmo_fire = st_q.pend && !int_clamp_mode &&
            (st_q.tmo == 24'(APPLY_DELAY - 1));
        st_d.offset_load = clamp_event | tmo_fire; // Always loads
        if (clamp_event || tmo_fire || !st_q.pend || int_clamp_mode) begin
            st_d.tmo = 24'h000000;
        end else begin
            st_d.tmo = st_q.tmo + 24'h000001;
        end
        // A write in the same cycle as a load keeps its pending flag
        st_d.pend = gain_offset_written | (st_q.pend & ~(clamp_event | tmo_fire));

        // Crystal output: pass, halve or hold low
        st_d.xtal_q = crystal_clock_input;
        if (rise(st_q.xtal_q, crystal_clock_input)) begin
            st_d.xtal_div = ~st_q.xtal_div;
        end
        if (st_q.misc[MISC_XTAL_OFF]) begin
            st_d.xtal_out = 1'b0;
        end else begin
            st_d.xtal_out = st_q.misc[MISC_XTAL_HALF] ? st_q.xtal_div
                                                      : st_q.xtal_q;
        end
    end

    // Single state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.bandwidth <= RST_BANDWIDTH;
            st_q.len_high <= RST_LEN_HIGH;
            st_q.len_low <= RST_LEN_LOW;
            st_q.phase <= RST_PHASE;
            st_q.hold_before <= RST_HOLD_BEFORE;
            st_q.hold_after <= RST_HOLD_AFTER;
            st_q.misc <= RST_MISC;
            st_q.start_high <= RST_START_HIGH;
            st_q.start_low <= RST_START_LOW;
            st_q.clamp_width <= RST_CLAMP_WIDTH;
            st_q.input_cfg <= RST_INPUT_CFG;
            st_q.black_cfg <= RST_BLACK_CFG;
            st_q.len_active <= {RST_LEN_HIGH[5:0], RST_LEN_LOW};
        end else begin
            st_q <= st_d;
        end
    end

    // Bus outputs from state
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // Settings straight from registers
    assign frontend_corner_select = st_q.bandwidth[CORNER_LSB +: 3];
    assign peaking_code = st_q.bandwidth[PEAK_LSB +: 4];
    assign loop_line_length = st_q.len_active;
    assign sample_phase_code = st_q.phase[5:0];

    // Loop and pin functions, all from flops
    assign loop_ref_pulse = st_q.ref_pulse;
    assign loop_hold = st_q.hold;
    assign clock_invert_active = st_q.pin_q &
        (st_q.misc[MISC_FN_LSB +: 2] == PCC_PIN_INVERT);
    assign external_pixel_clock_select =
        (st_q.misc[MISC_FN_LSB +: 2] == PCC_PIN_EXTERNAL_PIXEL_CLOCK);
    assign external_pixel_clock = st_q.pin_q & external_pixel_clock_select;

    // Clamp results and crystal output
    assign clamp_pulse = st_q.clamp;
    assign black_level_correction_start = st_q.blc_start;
    assign offset_update_pulse = st_q.offset_load;
    assign crystal_clock_output = st_q.xtal_out;

endmodule : pcc_top

/* File: tb/pcc_top_props.sv */
// Purpose: Bus handshake and clamp pulse checks.
// Assumes: Clamp pulse only rises from the internal generator.
// Notes: Bound to pcc_top.
`timescale 1ns/1ps
module pcc_top_props (
    // Clock, reset and handshakes
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Clamp results
    input wire logic clamp_pulse,
    input wire logic black_level_correction_start,
    input wire logic offset_update_pulse
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers stand until taken; nothing new accepted meanwhile
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during rvalid");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready during bvalid");
    a_clamp_min_width: assert property ($rose(clamp_pulse) |=> clamp_pulse)
        else $error("clamp shorter than two");
    a_clamp_at_start: assert property ($rose(clamp_pulse) |->
        black_level_correction_start) else $error("clamp off start pixel");
    a_start_loads_offset: assert property (black_level_correction_start |->
        offset_update_pulse) else $error("no offset load");
endmodule : pcc_top_props
bind pcc_top pcc_top_props i_pcc_top_props (.*);

/* File: tb/pcc_top_tb.sv */
// Purpose: Register and clamp tests for pcc_top.
// Assumes: Source model lines of 64 cycles.
// Notes: Windows of 512 cycles hold whole lines, so counts are exact.
`timescale 1ns/1ps
module pcc_top_tb
    import pcc_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, xo_q, tally_clr = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, peaking_code;
    logic clock_invert_input = 1'b0, gain_offset_written = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, first_line_sync_input, frame_sync_input;
    logic second_line_sync_input, crystal_clock_input, loop_ref_pulse, loop_hold, clamp_pulse;
    logic clock_invert_active, external_pixel_clock, external_pixel_clock_select;
    logic black_level_correction_start, offset_update_pulse, crystal_clock_output;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] frontend_corner_select;
    logic [13:0] loop_line_length;
    logic [5:0] sample_phase_code;
    int failures = 0, cmp_count = 0, n_clamp = 0, n_start = 0, n_ofs = 0, n_xo = 0, n_ref = 0;
    assign second_line_sync_input = first_line_sync_input;
    pcc_top #(.APPLY_DELAY(20)) i_pcc_top (.*);
    pcc_video_src i_pcc_video_src (.*);
    always #4 aclk = ~aclk;
    // Activity tallies for the measuring windows
    always @(posedge aclk) begin
        xo_q <= crystal_clock_output;
        if (tally_clr) begin
            {n_clamp, n_start, n_ofs, n_xo, n_ref} <= '0;
        end else begin
            n_clamp <= n_clamp + int'(clamp_pulse);
            n_start <= n_start + int'(black_level_correction_start);
            n_ofs <= n_ofs + int'(offset_update_pulse);
            n_xo <= n_xo + int'(crystal_clock_output && !xo_q);
            n_ref <= n_ref + int'(loop_ref_pulse);
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        int t;
        s_axi_awaddr <= {24'h0, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (t == 50) failures++;
        if (t == 50) results();
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [31:0] ex, input logic [1:0] er);
        int t;
        s_axi_araddr <= {24'h0, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (t == 50) failures++;
        if (t == 50) results();
        chk(s_axi_rdata, ex);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd
    // Settle a line first so a setting change never splits a pulse
    task automatic span;
        repeat (64) @(posedge aclk);
        tally_clr <= 1'b1;
        @(posedge aclk);
        tally_clr <= 1'b0;
        repeat (513) @(posedge aclk);
    endtask : span
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({25'h0, peaking_code, frontend_corner_select}, 32'h07);
        rd(IDX_BANDWIDTH, {24'h0, RST_BANDWIDTH}, RESP_OKAY);
        rd(IDX_LEN_LOW, {24'h0, RST_LEN_LOW}, RESP_OKAY);
        rd(IDX_CLAMP_WIDTH, {24'h0, RST_CLAMP_WIDTH}, RESP_OKAY);
        wr(IDX_BANDWIDTH, 8'h5a, RESP_OKAY);
        chk({25'h0, peaking_code, frontend_corner_select}, 32'h2d);
        wr(IDX_LEN_HIGH, 8'hff, RESP_OKAY);
        chk({18'h0, loop_line_length}, 32'h320);
        wr(IDX_LEN_LOW, 8'h00, RESP_OKAY);
        chk({18'h0, loop_line_length}, 32'h3f00);
        wr(IDX_PHASE, 8'hff, RESP_OKAY);
        chk({26'h0, sample_phase_code}, 32'h3f);
        rd(6'h3f, 32'h0, RESP_SLVERR);
        wr(6'h3e, 8'h01, RESP_SLVERR);
        wr(IDX_INPUT_CFG, 8'h20, RESP_OKAY);
        wr(IDX_START_LOW, 8'h05, RESP_OKAY);
        wr(IDX_CLAMP_WIDTH, 8'h03, RESP_OKAY);
        span();
        chk(n_start, 8);
        chk(n_clamp, 24);
        chk(n_ofs, 8);
        chk(n_xo, 64);
        chk(n_ref, 8);
        wr(IDX_CLAMP_WIDTH, 8'h01, RESP_OKAY);
        wr(IDX_MISC, 8'h40, RESP_OKAY);
        span();
        chk(n_clamp, 0);
        chk(n_start, 8);
        chk(n_xo, 32);
        wr(IDX_CLAMP_WIDTH, 8'h02, RESP_OKAY);
        wr(IDX_MISC, 8'h80, RESP_OKAY);
        span();
        chk(n_clamp, 16);
        chk(n_xo, 0);
        clock_invert_input <= 1'b1;
        wr(IDX_MISC, 8'h00, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, clock_invert_active, external_pixel_clock_select}, 32'h2);
        chk({31'h0, loop_hold}, 32'h1);
        wr(IDX_MISC, 8'h38, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, external_pixel_clock, external_pixel_clock_select}, 32'h1);
        wr(IDX_MISC, 8'h30, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, external_pixel_clock, external_pixel_clock_select}, 32'h3);
        clock_invert_input <= 1'b0;
        wr(IDX_MISC, 8'h20, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, loop_hold}, 32'h0);
        wr(IDX_INPUT_CFG, 8'h22, RESP_OKAY);
        span();
        chk(n_clamp, 0);
        chk(n_start, 8);
        wr(IDX_MISC, 8'h10, RESP_OKAY);
        tally_clr <= 1'b1;
        gain_offset_written <= 1'b1;
        @(posedge aclk);
        tally_clr <= 1'b0;
        gain_offset_written <= 1'b0;
        repeat (64) @(posedge aclk);
        chk(n_ofs, 1);
        chk(n_start, 0);
        clock_invert_input <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(n_ofs, 2);
        chk(n_start, 1);
        results();
    end
endmodule : pcc_top_tb

/* File: tb/pcc_video_src.sv */
// Purpose: Source model: line sync, frame sync and crystal clock.
// Assumes: 64-cycle lines with sync high for 8 cycles, 8 lines a frame.
// Notes: Crystal runs at aclk/8, below the aclk/2 sampling limit.
`timescale 1ns/1ps
module pcc_video_src (
    // Clock
    aclk,
    // Source outputs
    first_line_sync_input,
    frame_sync_input,
    crystal_clock_input
);
    input wire logic aclk;
    output logic first_line_sync_input;
    output logic frame_sync_input;
    output logic crystal_clock_input;
    logic [8:0] cnt_q = 9'h000;
    // Free-running raster; syncs lead each line and frame
    always_ff @(posedge aclk) begin
        cnt_q <= cnt_q + 9'h001;
    end
    assign first_line_sync_input = (cnt_q[5:0] < 6'h08);
    assign frame_sync_input = (cnt_q[8:6] == 3'h0);
    assign crystal_clock_input = cnt_q[2];
endmodule : pcc_video_src
